// ### bench/cpu_status_and_option_regs_tb_top.sv
// Self-checking bench for the status and option register bank
`timescale 1ns/1ns
`default_nettype none
`include "cpu_regs_consts.svh"
module cpu_status_and_option_regs_tb_top;
    logic                        clk, rstn, wdt_timeout, clrwdt_exec;
    logic                        sleep_exec, clr_file, bank_sel_lo;
    logic                        pullup_off, irq_rising, tmr_ext_src;
    logic                        tmr_fall_edge, ps_to_wdt, sub_op;
    cpu_regs_pkg::reset_kind_t   rst_kind;
    cpu_regs_pkg::core_wr_t      core_wr;
    logic [7:0]                  core_addr, core_rdata, tmr_div_log2;
    logic [7:0]                  wdt_div_log2, a_op, b_op, alu_res;
    logic                        alu_z, alu_dc, alu_c;
    logic [`AXI_ADDR_W-1:0]      s_awaddr, s_araddr;
    logic [31:0]                 s_wdata, s_rdata;
    logic [3:0]                  s_wstrb;
    logic [1:0]                  s_bresp, s_rresp;
    logic                        s_awvalid, s_awready, s_wvalid, s_wready;
    logic                        s_bvalid, s_bready, s_arvalid, s_arready;
    logic                        s_rvalid, s_rready;
    logic [33:0]                 rq[$];
    logic [1:0]                  bq[$];
    integer                      err_total, n_checks, seed, i;
    logic [7:0]                  o;

    cpu_status_and_option_regs u_cpu_status_and_option_regs (.*);
    alu_flag_calc u_alu_flag_calc (.a(a_op), .b(b_op), .sub(sub_op),
        .result(alu_res), .zero(alu_z), .dc(alu_dc), .carry(alu_c));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [11:0] ba(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction

    task automatic bump(input string nm, input logic [33:0] e, g);
        n_checks++;
        if (e !== g) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rd(input logic [33:0] e, g);
        bump("read", e, g);
    endtask
    task automatic chk_b(input logic [1:0] e, g);
        bump("bresp", {32'h0, e}, {32'h0, g});
    endtask
    task automatic chk_out(input string nm, input logic [7:0] e, g);
        bump(nm, {26'h0, e}, {26'h0, g});
    endtask

    task automatic final_report;
        $display("Checks %0d, errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic hang_check(input integer n);
        if (n >= 50) begin
            err_total++;
            $display("MISMATCH handshake expected answer seen none");
            final_report();
        end
    endtask

    // Expectations are noted before the request; the monitor pops them
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d,
                          input logic [3:0] st, input logic [1:0] er);
        integer n;
        bq.push_back(er);
        @(posedge clk);
        s_awaddr <= a;
        s_awvalid <= 1'b1;
        s_wdata <= {$random(seed) & 32'hFFFFFF00} | 32'(d);
        s_wstrb <= st;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            n++;
        end while (!s_bvalid && n < 50);
        s_bready <= 1'b0;
        hang_check(n);
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [7:0] d,
                          input logic [1:0] er);
        integer n;
        rq.push_back({er, 24'h0, d});
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            if (s_arready) s_arvalid <= 1'b0;
            n++;
        end while (!s_rvalid && n < 50);
        s_rready <= 1'b0;
        hang_check(n);
    endtask

    task automatic core_op(input logic [7:0] a, input logic [14:0] w,
                           input logic cf);
        @(posedge clk);
        core_addr <= a;
        core_wr <= w;
        clr_file <= cf;
        @(posedge clk);
        core_wr <= '0;
        clr_file <= 1'b0;
    endtask

    // Bits are watchdog time-out, sleep, clear-watchdog
    task automatic ev(input logic [2:0] e, cpu_regs_pkg::reset_kind_t k);
        @(posedge clk);
        {wdt_timeout, sleep_exec, clrwdt_exec} <= e;
        rst_kind <= k;
        @(posedge clk);
        {wdt_timeout, sleep_exec, clrwdt_exec} <= 3'b000;
        rst_kind <= cpu_regs_pkg::RST_NONE;
    endtask

    always @(posedge clk) begin
        if (s_rvalid && s_rready) chk_rd(rq.pop_front(), {s_rresp, s_rdata});
        if (s_bvalid && s_bready) chk_b(bq.pop_front(), s_bresp);
    end

    localparam logic [11:0] ST = 12'(`STATUS_IDX * 4);
    localparam logic [11:0] SM = 12'(`STATUS_MIRROR * 4);
    localparam logic [11:0] OP = 12'(`OPTION_IDX * 4);
    initial begin
        err_total = 0; n_checks = 0; seed = 32'h21B0;
        rstn = 1'b0; rst_kind = cpu_regs_pkg::RST_NONE; core_wr = '0;
        {wdt_timeout, clrwdt_exec, sleep_exec, clr_file} = 4'h0;
        core_addr = 8'h00; s_awaddr = '0; s_araddr = '0; s_wdata = '0;
        s_wstrb = 4'h0; {s_awvalid, s_wvalid, s_bready} = 3'b000;
        {s_arvalid, s_rready} = 2'b00; a_op = 8'h00; b_op = 8'h00;
        sub_op = 1'b1;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        axi_rd(ST, 8'h18, `RESP_OKAY);
        axi_rd(SM, 8'h18, `RESP_OKAY);
        axi_rd(OP, 8'hFF, `RESP_OKAY);
        axi_rd(12'h400, 8'h00, `RESP_SLVERR);
        axi_wr(12'h7FC, 8'h55, 4'hF, `RESP_SLVERR);
        axi_wr(ST, 8'h00, 4'hF, `RESP_OKAY);
        axi_rd(ST, 8'h18, `RESP_OKAY);
        axi_wr(ST, 8'h27, 4'hF, `RESP_OKAY);
        axi_rd(SM, 8'h3F, `RESP_OKAY);
        axi_wr(ST, 8'h00, 4'hE, `RESP_OKAY);
        axi_rd(ST, 8'h3F, `RESP_OKAY);
        chk_out("bank_sel_lo", 8'h01, {7'h0, bank_sel_lo});
        core_op(`STATUS_IDX, {8'h00, 7'b1111010}, 1'b0);
        axi_rd(ST, 8'h1A, `RESP_OKAY);
        core_op(`STATUS_MIRROR, {8'h23, 7'b1000000}, 1'b0);
        axi_rd(ST, 8'h3B, `RESP_OKAY);
        core_op(`STATUS_IDX, {8'h00, 7'b1100100}, 1'b1);
        core_addr <= `STATUS_MIRROR;
        repeat (2) @(posedge clk);
        #1 chk_out("core_rdata", 8'h1F, core_rdata);
        ev(3'b100, cpu_regs_pkg::RST_NONE);
        axi_rd(ST, 8'h0F, `RESP_OKAY);
        ev(3'b010, cpu_regs_pkg::RST_NONE);
        axi_rd(ST, 8'h17, `RESP_OKAY);
        ev(3'b001, cpu_regs_pkg::RST_NONE);
        axi_rd(ST, 8'h1F, `RESP_OKAY);
        for (i = 0; i < 16; i++) begin
            o = {4'($random(seed)), 4'(i)};
            axi_wr(OP, o, 4'h1, `RESP_OKAY);
            axi_rd(OP, o, `RESP_OKAY);
            chk_out("opt_bits", o & 8'hF8, {pullup_off, irq_rising,
                tmr_ext_src, tmr_fall_edge, ps_to_wdt, 3'b000});
            chk_out("tmr_div", o[3] ? 8'h00 : 8'(o[2:0]) + 8'h01,
                tmr_div_log2);
            chk_out("wdt_div", o[3] ? 8'(o[2:0]) : 8'h00,
                wdt_div_log2);
        end
        core_op(`OPTION_IDX, {8'hA5, 7'b1000000}, 1'b0);
        axi_rd(OP, 8'hA5, `RESP_OKAY);
        chk_out("irq_rising", 8'h00, {7'h0, irq_rising});
        axi_wr(ST, 8'h27, 4'hF, `RESP_OKAY);
        ev(3'b000, cpu_regs_pkg::RST_OTHER);
        axi_rd(ST, 8'h1F, `RESP_OKAY);
        axi_rd(OP, 8'hFF, `RESP_OKAY);
        ev(3'b000, cpu_regs_pkg::RST_POWERUP);
        axi_rd(ST, 8'h18, `RESP_OKAY);
        // Subtraction cases: nibble borrow, full borrow, plain, zero
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            a_op <= i[0] ? (i[1] ? 8'h05 : 8'h03) : (i[1] ? 8'h05 : 8'h10);
            b_op <= i[0] ? (i[1] ? 8'h05 : 8'h05) : (i[1] ? 8'h03 : 8'h01);
            #1;
            chk_out("sub_res", a_op - b_op, alu_res);
            chk_out("sub_flags", {5'h0, a_op == b_op, a_op[3:0] >= b_op[3:0],
                a_op >= b_op}, {5'h0, alu_z, alu_dc, alu_c});
        end
        repeat (3) @(posedge clk);
        final_report();
    end
endmodule
`default_nettype wire

// ### rtl/alu_flag_calc.sv
// Flag computation for add and subtract results
`timescale 1ns/1ns
`default_nettype none
module alu_flag_calc (
    input  wire logic [7:0] a,        // First operand
    input  wire logic [7:0] b,        // Second operand
    input  wire logic       sub,      // High for a minus b
    output logic      [7:0] result,   // Arithmetic result
    output logic            zero,     // Result is zero
    output logic            dc,       // Digit carry or inverted borrow
    output logic            carry     // Carry or inverted borrow
);
    // Subtraction adds the two's complement, so carries are inverted borrows
    wire logic [7:0] b_eff;
    wire logic [8:0] sum;
    wire logic [4:0] low;
    assign b_eff = sub ? ~b : b;
    assign sum   = {1'b0, a} + {1'b0, b_eff} + {8'h00, sub};
    assign low   = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, sub};
    assign result = sum[7:0];
    assign zero   = (sum[7:0] == 8'h00);
    assign dc     = low[4];
    assign carry  = sum[8];
endmodule
`default_nettype wire

// ### rtl/cpu_regs_consts.svh
// Constants for the status and option register bank
`ifndef CPU_REGS_CONSTS_SVH
`define CPU_REGS_CONSTS_SVH
// Overview of operation
// - ALU flag update overrides status register write, except zero on clear-file
// - Timeout and powerdown flags ignore instruction writes
// - Status register accepted as any destination
// - Bank select low bit picks bank
// - Subtraction carries are inverted borrows
// - Clear-file zeros upper bits, sets zero
// - Status mirrored at 03h and 83h
// - Unimplemented bits and addresses read zero
// - Power-up and other resets differ
// - Option register fully readable and writable
// - Option bit 7 disables port pull-ups
// - Edge select: one rising, zero falling
// - Prescaler assign: watchdog or timer 1:1
`define STATUS_IDX       8'h03
`define STATUS_MIRROR    8'h83
`define OPTION_IDX       8'h81
`define CTRL_IDX         8'hC0
`define AXI_ADDR_W       12
`define OPTION_RST       8'hFF
`define STATUS_POR       8'h18
`define BIT_CARRY        0
`define BIT_DCARRY       1
`define BIT_ZERO         2
`define BIT_PD           3
`define BIT_TO           4
`define BIT_BANK_LO      5
`define BIT_OPT_PULLUP   7
`define BIT_OPT_EDGE     6
`define BIT_OPT_SRC      5
`define BIT_OPT_SEDGE    4
`define BIT_OPT_PSA      3
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// ### rtl/cpu_regs_pkg.sv
// Types shared by the status and option register bank
package cpu_regs_pkg;
    typedef struct packed {
        logic       pullup_disable_n;
        logic       ext_irq_edge_sel;
        logic       timer_clk_src;
        logic       timer_src_edge;
        logic       prescaler_assign;
        logic [2:0] prescale_rate;
    } option_t;

    typedef struct packed {
        logic [7:0] data;
        logic       dest_wr;
        logic       upd_zero;
        logic       upd_dc;
        logic       upd_carry;
        logic       alu_zero;
        logic       alu_dc;
        logic       alu_carry;
    } core_wr_t;

    typedef enum logic [1:0] {
        RST_NONE    = 2'b00,
        RST_POWERUP = 2'b01,
        RST_OTHER   = 2'b10
    } reset_kind_t;
endpackage

// ### rtl/cpu_status_and_option_regs.sv
// Status and option registers with core port and AXI4-Lite slave
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_regs_consts.svh"
module cpu_status_and_option_regs (
    input  wire logic                   clk,          // 250 MHz clock
    input  wire logic                   rstn,         // Async reset, low
    input  wire cpu_regs_pkg::reset_kind_t rst_kind,  // Reset cause, pulse
    input  wire logic                   wdt_timeout,  // Watchdog time-out
    input  wire logic                   clrwdt_exec,  // Clear-watchdog run
    input  wire logic                   sleep_exec,   // Sleep run
    input  wire logic [7:0]             core_addr,    // Core file address
    input  wire cpu_regs_pkg::core_wr_t core_wr,      // Core write bundle
    input  wire logic                   clr_file,     // Clear-file instr
    output logic [7:0]                  core_rdata,   // Core read data
    output logic                        bank_sel_lo,  // Direct bank select
    output logic                        pullup_off,   // All pull-ups off
    output logic                        irq_rising,   // Rising edge irq
    output logic                        tmr_ext_src,  // Timer on pin
    output logic                        tmr_fall_edge,// Count on falling
    output logic                        ps_to_wdt,    // Prescaler on wdt
    output logic [7:0]                  tmr_div_log2, // Timer divide log2
    output logic [7:0]                  wdt_div_log2, // Watchdog divide log2
    input  wire logic [`AXI_ADDR_W-1:0] s_awaddr,     // AXI write addr
    input  wire logic                   s_awvalid,    // AXI aw valid
    output logic                        s_awready,    // AXI aw ready
    input  wire logic [31:0]            s_wdata,      // AXI write data
    input  wire logic [3:0]             s_wstrb,      // AXI byte enables
    input  wire logic                   s_wvalid,     // AXI w valid
    output logic                        s_wready,     // AXI w ready
    output logic [1:0]                  s_bresp,      // AXI write resp
    output logic                        s_bvalid,     // AXI b valid
    input  wire logic                   s_bready,     // AXI b ready
    input  wire logic [`AXI_ADDR_W-1:0] s_araddr,     // AXI read addr
    input  wire logic                   s_arvalid,    // AXI ar valid
    output logic                        s_arready,    // AXI ar ready
    output logic [31:0]                 s_rdata,      // AXI read data
    output logic [1:0]                  s_rresp,      // AXI read resp
    output logic                        s_rvalid,     // AXI r valid
    input  wire logic                   s_rready      // AXI r ready
);
    logic [7:0]            status_ff;
    logic [7:0]            nxt_status;
    cpu_regs_pkg::option_t option_ff;
    cpu_regs_pkg::option_t nxt_option;
    logic                  awready_ff, wready_ff, arready_ff;
    logic [7:0]            core_rdata_ff;
    logic                  bank_ff, pull_ff, edge_ff, src_ff, sedge_ff;
    logic                  psw_ff;
    logic [7:0]            tdiv_ff, wdiv_ff;
    logic [`AXI_ADDR_W-1:0] awaddr_ff;
    logic [31:0]           wdata_ff;
    logic [3:0]            wstrb_ff;
    logic                  aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
    logic [1:0]            bresp_ff, rresp_ff;
    logic [31:0]           rdata_ff;
    wire  logic [7:0]      tdiv_w, wdiv_w;
    wire  logic            psw_w;

    // Register index from a byte address; unaligned or high bits miss
    function automatic logic [8:0] reg_idx(input logic [`AXI_ADDR_W-1:0] a);
        reg_idx = (a[1:0] == 2'b00 && a[`AXI_ADDR_W-1:10] == '0) ?
                  {1'b1, a[9:2]} : 9'h000;
    endfunction

    function automatic logic is_status(input logic [7:0] idx);
        is_status = (idx == `STATUS_IDX) || (idx == `STATUS_MIRROR);
    endfunction

    function automatic logic [7:0] read_reg(input logic [7:0] idx);
        if (is_status(idx))
            read_reg = status_ff;
        else if (idx == `OPTION_IDX)
            read_reg = option_ff;
        else
            read_reg = 8'h00;
    endfunction

    // Core write path: mirrored status accepted as any destination
    wire logic core_st_wr = core_wr.dest_wr && is_status(core_addr);
    wire logic core_op_wr = core_wr.dest_wr &&
                            (core_addr == `OPTION_IDX);
    // AXI write fires once both address and data are held
    wire logic axi_wr     = aw_got_ff && w_got_ff && !bvalid_ff;
    wire logic [8:0] w_idx = reg_idx(awaddr_ff);
    wire logic axi_hit_st = axi_wr && w_idx[8] && is_status(w_idx[7:0])
                            && wstrb_ff[0];
    wire logic axi_hit_op = axi_wr && w_idx[8] &&
                            (w_idx[7:0] == `OPTION_IDX) && wstrb_ff[0];
    wire logic axi_map    = w_idx[8] && (is_status(w_idx[7:0]) ||
                            w_idx[7:0] == `OPTION_IDX);
    wire logic [8:0] r_idx = reg_idx(s_araddr);
    wire logic r_map      = r_idx[8] && (is_status(r_idx[7:0]) ||
                            r_idx[7:0] == `OPTION_IDX);
    wire logic ar_take    = s_arvalid && !rvalid_ff;

    // Next status: bank and flags writable, reset-cause bits only by events
    always_comb begin
        nxt_status = status_ff;
        if (axi_hit_st) begin
            nxt_status[7:5] = wdata_ff[7:5];
            nxt_status[2:0] = wdata_ff[2:0];
        end
        if (core_st_wr) begin
            nxt_status[7:5] = core_wr.data[7:5];
            nxt_status[2:0] = core_wr.data[2:0];
        end
        if (clr_file && core_st_wr) begin
            nxt_status[7:5] = 3'h0;
            nxt_status[`BIT_ZERO] = 1'b1;
            nxt_status[1:0] = status_ff[1:0];
        end
        // ALU-driven flags win over the register write to them, except zero during a status clear-file
        if (core_wr.upd_zero && !(clr_file && core_st_wr))
            nxt_status[`BIT_ZERO] = core_wr.alu_zero;
        if (core_wr.upd_dc)
            nxt_status[`BIT_DCARRY] = core_wr.alu_dc;
        if (core_wr.upd_carry)
            nxt_status[`BIT_CARRY] = core_wr.alu_carry;
        // Only reset, watchdog and sleep touch these two bits
        if (clrwdt_exec) begin
            nxt_status[`BIT_TO] = 1'b1;
            nxt_status[`BIT_PD] = 1'b1;
        end
        if (sleep_exec) begin
            nxt_status[`BIT_TO] = 1'b1;
            nxt_status[`BIT_PD] = 1'b0;
        end
        if (wdt_timeout)
            nxt_status[`BIT_TO] = 1'b0;
        if (rst_kind == cpu_regs_pkg::RST_POWERUP)
            nxt_status = `STATUS_POR;
        else if (rst_kind == cpu_regs_pkg::RST_OTHER)
            nxt_status[7:5] = 3'h0;
    end

    always_comb begin
        nxt_option = option_ff;
        if (axi_hit_op)
            nxt_option = wdata_ff[7:0];
        if (core_op_wr)
            nxt_option = core_wr.data;
        if (rst_kind != cpu_regs_pkg::RST_NONE)
            nxt_option = `OPTION_RST;
    end

    // Hardware reset is the power-up set; flags start cleared here
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_ff   <= `STATUS_POR;
            option_ff   <= `OPTION_RST;
        end else begin
            status_ff   <= nxt_status;
            option_ff   <= nxt_option;
        end
    end

    prescale_decode u_ps (
        .opt          (option_ff),
        .tmr_div_log2 (tdiv_w),
        .wdt_div_log2 (wdiv_w),
        .ps_to_wdt    (psw_w)
    );

    // Outputs are registered, so they lag the register by one cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            core_rdata_ff <= 8'h00;
            bank_ff  <= 1'b0;
            pull_ff  <= 1'b1;
            edge_ff  <= 1'b1;
            src_ff   <= 1'b1;
            sedge_ff <= 1'b1;
            psw_ff   <= 1'b1;
            tdiv_ff  <= 8'h00;
            wdiv_ff  <= 8'h07;
        end else begin
            core_rdata_ff <= read_reg(core_addr);
            bank_ff  <= status_ff[`BIT_BANK_LO];
            pull_ff  <= option_ff.pullup_disable_n;
            edge_ff  <= option_ff.ext_irq_edge_sel;
            src_ff   <= option_ff.timer_clk_src;
            sedge_ff <= option_ff.timer_src_edge;
            psw_ff   <= psw_w;
            tdiv_ff  <= tdiv_w;
            wdiv_ff  <= wdiv_w;
        end
    end

    // AXI4-Lite slave: aw and w taken in either order, one write at a time
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            awaddr_ff <= '0;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= `RESP_OKAY;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
        end else begin
            // Ready flops track !got && !bvalid so no output is combinational
            if (s_awvalid && !aw_got_ff && !bvalid_ff) begin
                awaddr_ff <= s_awaddr;
                aw_got_ff <= 1'b1;
                awready_ff <= 1'b0;
            end
            if (s_wvalid && !w_got_ff && !bvalid_ff) begin
                wdata_ff <= s_wdata;
                wstrb_ff <= s_wstrb;
                w_got_ff <= 1'b1;
                wready_ff <= 1'b0;
            end
            if (axi_wr) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= axi_map ? `RESP_OKAY : `RESP_SLVERR;
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
            end else if (bvalid_ff && s_bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `RESP_OKAY;
            arready_ff <= 1'b1;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            arready_ff <= 1'b0;
            rdata_ff  <= {24'h000000, r_idx[8] ? read_reg(r_idx[7:0])
                                               : 8'h00};
            rresp_ff  <= r_map ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_ff && s_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    assign s_awready     = awready_ff;
    assign s_wready      = wready_ff;
    assign s_bvalid      = bvalid_ff;
    assign s_bresp       = bresp_ff;
    assign s_arready     = arready_ff;
    assign s_rvalid      = rvalid_ff;
    assign s_rdata       = rdata_ff;
    assign s_rresp       = rresp_ff;
    assign core_rdata    = core_rdata_ff;
    assign bank_sel_lo   = bank_ff;
    assign pullup_off    = pull_ff;
    assign irq_rising    = edge_ff;
    assign tmr_ext_src   = src_ff;
    assign tmr_fall_edge = sedge_ff;
    assign ps_to_wdt     = psw_ff;
    assign tmr_div_log2  = tdiv_ff;
    assign wdt_div_log2  = wdiv_ff;

    flag_override_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (core_wr.upd_carry && rst_kind != cpu_regs_pkg::RST_POWERUP)
        |=> status_ff[`BIT_CARRY] == $past(core_wr.alu_carry))
        else $error("carry not taken from alu");
    reset_cause_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (rst_kind == cpu_regs_pkg::RST_NONE && !wdt_timeout && !clrwdt_exec
         && !sleep_exec) |=> $stable(status_ff[4:3]))
        else $error("reset cause bits changed by write");
    clear_file_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (clr_file && core_st_wr && !core_wr.upd_dc && !core_wr.upd_carry &&
         rst_kind == cpu_regs_pkg::RST_NONE)
        |=> status_ff[7:5] == 3'h0 && status_ff[`BIT_ZERO] &&
            status_ff[1:0] == $past(status_ff[1:0]))
        else $error("clear file result wrong");
    bank_out_a: assert property (
        @(posedge clk) disable iff (!rstn)
        ##1 bank_sel_lo == $past(status_ff[`BIT_BANK_LO]))
        else $error("bank select lags wrong");
    timer_ratio_a: assert property (
        @(posedge clk) disable iff (!rstn)
        !option_ff.prescaler_assign |-> ##1
        tmr_div_log2 == {5'h00, $past(option_ff.prescale_rate)} + 8'h01)
        else $error("timer ratio wrong");
    wdt_one_a: assert property (
        @(posedge clk) disable iff (!rstn)
        option_ff.prescaler_assign |=> tmr_div_log2 == 8'h00 && ps_to_wdt)
        else $error("timer not 1:1 with prescaler on wdt");
    power_reset_a: assert property (
        @(posedge clk) disable iff (!rstn)
        rst_kind == cpu_regs_pkg::RST_POWERUP |=>
        status_ff == `STATUS_POR && option_ff == `OPTION_RST)
        else $error("power-up values wrong");
    sleep_pd_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (sleep_exec && !wdt_timeout && rst_kind == cpu_regs_pkg::RST_NONE)
        |=> !status_ff[`BIT_PD] && status_ff[`BIT_TO])
        else $error("sleep flags wrong");
    unmapped_read_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (ar_take && !r_map) |=> s_rdata == 32'h0 && s_rresp == `RESP_SLVERR)
        else $error("unmapped read not zero");
    opt_out_a: assert property (
        @(posedge clk) disable iff (!rstn)
        ##1 {pullup_off, irq_rising, tmr_ext_src, tmr_fall_edge} ==
            $past(option_ff[7:4]))
        else $error("option field outputs wrong");
    axi_opt_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (axi_hit_op && !core_op_wr && rst_kind == cpu_regs_pkg::RST_NONE)
        |=> option_ff == $past(wdata_ff[7:0]))
        else $error("option write not taken");
endmodule
`default_nettype wire

// ### rtl/prescale_decode.sv
// Prescaler routing and divide ratio decode from the option fields
`timescale 1ns/1ns
`default_nettype none
module prescale_decode (
    input  wire cpu_regs_pkg::option_t opt,        // Option fields
    output logic [7:0]                 tmr_div_log2, // Timer divide, log2
    output logic [7:0]                 wdt_div_log2, // Watchdog divide, log2
    output logic                       ps_to_wdt     // Prescaler on watchdog
);
    assign ps_to_wdt    = opt.prescaler_assign;
    assign tmr_div_log2 = opt.prescaler_assign ? 8'h00 :
                          {5'h00, opt.prescale_rate} + 8'h01;
    assign wdt_div_log2 = opt.prescaler_assign ?
                          {5'h00, opt.prescale_rate} : 8'h00;
endmodule
`default_nettype wire
